// file: tpa_pkg.sv
// Shared constants and types for the transmit input and phase-align front end
package tpa_pkg;

  // Reference clock and character timing
  localparam int SYS_PERIOD_NS = 25;
  localparam int CHAR_PERIOD_NS = 200;
  localparam int CHAR_TICKS = (CHAR_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  // Word Sync Sequence length in K28.5 characters
  localparam int WSS_LEN = 16;

  // Phase-align buffer depth, power of two
  localparam int BUF_DEPTH = 4;

  // Raw 10-bit word that asks for a Word Sync Sequence: control 01, data BC
  localparam logic [9:0] WSS_CMD = 10'h1bc;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;

  // Register decode results
  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam logic [2:0] SEL_STATUS = 3'h1;
  localparam logic [2:0] SEL_STAT = 3'h2;
  localparam logic [2:0] SEL_MASK = 3'h3;
  localparam logic [2:0] SEL_NONE = 3'h4;

  // Field layout
  localparam int CTRL_W = 1;
  localparam int CTRL_SOFT_INIT = 0;
  localparam int ST_ERR = 0;
  localparam int ST_BYPASS = 1;
  localparam int ST_RUN = 2;
  localparam int ST_WSS = 3;
  localparam int IRQ_W = 2;
  localparam int IRQ_PHASE_ERR = 0;
  localparam int IRQ_RECENTRE = 1;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 1'h0;
  localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Three-level select pin, coded as two bits
  typedef enum logic [1:0] {
    LVL_LOW = 2'b00,
    LVL_MID = 2'b01,
    LVL_HIGH = 2'b10
  } tpa_level_e;

  typedef enum logic [2:0] {
    KIND_DATA = 3'b001,
    KIND_C07 = 3'b010,
    KIND_K285 = 3'b100
  } tpa_kind_e;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_RUNNING = 2'b10
  } tpa_state_e;

  // Asynchronous pins, in synchroniser order
  typedef struct packed {
    logic clk;
    logic init_n;
    logic cksel;
    logic dbl;
    tpa_level_e mode_hi;
    tpa_level_e mode_lo;
    logic sc;
    logic [1:0] ct;
    logic [7:0] d;
  } tpa_pins_s;

  // One captured character
  typedef struct packed {
    logic [9:0] word;
    logic sc;
  } tpa_entry_s;

  // Character handed to the parity and encoder stage
  typedef struct packed {
    logic [9:0] word;
    logic sc;
    logic encode;
    tpa_kind_e kind;
  } tpa_char_s;

endpackage : tpa_pkg

// file: tpa_phase_buf.sv
// Phase-align buffer: slot array with write and read pointers and slip detect
`timescale 1ns/1ps
`default_nettype none
module tpa_phase_buf #(
  parameter int DEPTH = tpa_pkg::BUF_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic centre,
  input wire logic wr_en,
  input wire tpa_pkg::tpa_entry_s wr_data,
  input wire logic rd_en,
  output var tpa_pkg::tpa_entry_s rd_data,
  output logic slip
);
  localparam int PW = $clog2(DEPTH) + 1;

  tpa_pkg::tpa_entry_s mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW-1:0] occ;

  assign occ = wr_q - rd_q;
  assign rd_data = mem_q[rd_q[PW-2:0]];
  // Underflow on read of an empty buffer, overflow on write of a full one with no read in the same cycle
  assign slip = (rd_en && (occ == '0)) || (wr_en && !rd_en && (occ == PW'(DEPTH)));

  always_ff @(posedge sys_clk) begin : wr_ptr
    if (!rst_n) begin
      wr_q <= '0;
    end else if (wr_en) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin : slots
    if (wr_en) begin
      mem_q[wr_q[PW-2:0]] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin : rd_ptr
    if (!rst_n) begin
      rd_q <= '0;
    end else if (centre) begin
      rd_q <= wr_q - PW'(DEPTH / 2);
    end else if (rd_en && (occ != '0)) begin
      rd_q <= rd_q + 1'b1;
    end
  end

  centre_occ_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (centre && !wr_en) |=> (occ == PW'(DEPTH / 2)))
    else $error("buffer not centred after init");

endmodule : tpa_phase_buf
`default_nettype wire

// file: tpa_tx_front.sv
// Transmit input register, phase-align crossing and register slave
// Operation
// - Encoder bypassed: character bits plus control bits form one 10-bit word.
// - Each input clock latches eight character and two control bits.
// - Upper mode select not LOW enables encoding with the control bits.
// - Lower mode select not HIGH also latches special character select.
// - Source select and double-edge both LOW: buffer skipped, reference timing.
// - Otherwise the phase-align buffer carries characters to the character clock.
// - Buffer init input LOW on two consecutive edges initialises the buffer.
// - Release of the init input fixes the buffer centre point.
// - Buffer init input is synchronised before the state machine uses it.
// - Host keeps input clock drift within half a character period.
// - Buffer slip raises the error output until the buffer is reinitialised.
// - While the phase error stands, C0.7 characters replace host data.
// - In middle upper mode a Word Sync Sequence recentres and clears error.
// - A Word Sync Sequence is sixteen consecutive K28.5 characters.
`timescale 1ns/1ps
`default_nettype none
module tpa_tx_front #(
  parameter int ADDR_W = 8,
  parameter int BUF_DEPTH = tpa_pkg::BUF_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tx_input_clock,
  input wire logic phase_buffer_init_n,
  input wire logic [7:0] tx_char_bits,
  input wire logic [1:0] tx_control_bits,
  input wire logic special_char_select,
  input wire logic [3:0] tx_mode_select,
  input wire logic tx_input_clock_source_sel,
  input wire logic tx_double_edge_capture,
  output var tpa_pkg::tpa_char_s enc_char,
  output logic enc_char_valid,
  output logic tx_error_flag,
  output logic irq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int PIN_W = $bits(tpa_pkg::tpa_pins_s);
  localparam int DIV_W = $clog2(tpa_pkg::CHAR_TICKS) + 1;
  localparam int WSS_W = $clog2(tpa_pkg::WSS_LEN) + 1;

  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [2:0] s;
    if (a == ADDR_W'(tpa_pkg::ADDR_CTRL)) begin
      s = tpa_pkg::SEL_CTRL;
    end else if (a == ADDR_W'(tpa_pkg::ADDR_STATUS)) begin
      s = tpa_pkg::SEL_STATUS;
    end else if (a == ADDR_W'(tpa_pkg::ADDR_IRQ_STAT)) begin
      s = tpa_pkg::SEL_STAT;
    end else if (a == ADDR_W'(tpa_pkg::ADDR_IRQ_MASK)) begin
      s = tpa_pkg::SEL_MASK;
    end else begin
      s = tpa_pkg::SEL_NONE;
    end
    return s;
  endfunction : reg_sel

  tpa_pkg::tpa_pins_s pins_raw;
  tpa_pkg::tpa_pins_s pf;
  logic [PIN_W-1:0] sync1_q, sync2_q, sync3_q, pin_f_q;
  tpa_pkg::tpa_entry_s pin_entry, buf_out, cur, wss_src;
  tpa_pkg::tpa_state_e st_q;
  tpa_pkg::tpa_char_s char_q;
  logic [DIV_W-1:0] div_q;
  logic [WSS_W-1:0] wss_cnt_q;
  logic tick_q, clk_prev_q, valid_q, phase_err_q, irq_q;
  logic bypass, run, init_low, centre_go, cap_edge, buf_wr, buf_rd, buf_centre, buf_slip;
  logic wss_go, recentre, err_set;
  logic [tpa_pkg::CTRL_W-1:0] ctrl_q;
  logic [tpa_pkg::IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set, irq_clr;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, wr_go;
  logic [1:0] bresp_q, rresp_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rd_word;
  logic [3:0] wstrb_q;
  logic [2:0] wr_sel, rd_sel;

  assign pins_raw = '{clk: tx_input_clock, init_n: phase_buffer_init_n,
                      cksel: tx_input_clock_source_sel, dbl: tx_double_edge_capture,
                      mode_hi: tpa_pkg::tpa_level_e'(tx_mode_select[3:2]),
                      mode_lo: tpa_pkg::tpa_level_e'(tx_mode_select[1:0]),
                      sc: special_char_select, ct: tx_control_bits, d: tx_char_bits};

  // Three stages; a bit moves on once stages two and three agree
  always_ff @(posedge sys_clk) begin : pin_sync
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      pin_f_q <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_f_q <= ((sync2_q ~^ sync3_q) & sync3_q) | ((sync2_q ^ sync3_q) & pin_f_q);
    end
  end

  assign pf = pin_f_q;
  assign bypass = !pf.cksel && !pf.dbl;
  assign run = (st_q == tpa_pkg::ST_RUNNING);

  always_comb begin
    pin_entry.word = {pf.ct, pf.d};
    pin_entry.sc = (pf.mode_lo != tpa_pkg::LVL_HIGH) && pf.sc;
  end

  // Internal character clock enable
  always_ff @(posedge sys_clk) begin : char_div
    if (!rst_n) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == '0) begin
      div_q <= DIV_W'(tpa_pkg::CHAR_TICKS - 1);
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q - 1'b1;
      tick_q <= 1'b0;
    end
  end

  assign init_low = !pf.init_n || ctrl_q[tpa_pkg::CTRL_SOFT_INIT];
  assign centre_go = (st_q == tpa_pkg::ST_HOLD) && !init_low;

  always_ff @(posedge sys_clk) begin : init_fsm
    if (!rst_n) begin
      st_q <= tpa_pkg::ST_HOLD;
    end else begin
      case (st_q)
        tpa_pkg::ST_HOLD: begin
          if (!init_low) begin
            st_q <= tpa_pkg::ST_RUNNING;
          end
        end
        tpa_pkg::ST_RUNNING: begin
          if (init_low) begin
            st_q <= tpa_pkg::ST_HOLD;
          end
        end
        default: begin
          st_q <= tpa_pkg::ST_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin : clk_edge
    if (!rst_n) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= pf.clk;
    end
  end

  // Rising edge, plus falling edge in double-edge capture
  assign cap_edge = (pf.clk && !clk_prev_q) || (pf.dbl && !pf.clk && clk_prev_q);
  assign buf_wr = run && !bypass && cap_edge;
  assign buf_rd = run && !bypass && tick_q;
  assign buf_centre = centre_go || recentre;

  tpa_phase_buf #(
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .centre(buf_centre),
    .wr_en(buf_wr),
    .wr_data(pin_entry),
    .rd_en(buf_rd),
    .rd_data(buf_out),
    .slip(buf_slip)
  );

  assign cur = bypass ? pin_entry : buf_out;
  // Buffer contents are stale while in error, so watch the pins directly
  assign wss_src = (phase_err_q || bypass) ? pin_entry : buf_out;
  assign wss_go = tick_q && run && (pf.mode_hi == tpa_pkg::LVL_MID) && (wss_cnt_q == '0)
                  && (wss_src.word == tpa_pkg::WSS_CMD);
  assign recentre = wss_go && phase_err_q && !bypass;
  assign err_set = buf_slip && run && !bypass && !phase_err_q;

  always_ff @(posedge sys_clk) begin : wss_count
    if (!rst_n) begin
      wss_cnt_q <= '0;
    end else if (wss_go) begin
      wss_cnt_q <= WSS_W'(tpa_pkg::WSS_LEN - 1);
    end else if (tick_q && (wss_cnt_q != '0)) begin
      wss_cnt_q <= wss_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin : phase_err
    if (!rst_n) begin
      phase_err_q <= 1'b0;
    end else if (bypass || buf_centre || !run) begin
      phase_err_q <= 1'b0;
    end else if (buf_slip && run) begin
      phase_err_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin : char_out
    if (!rst_n) begin
      char_q <= '{word: 10'h000, sc: 1'b0, encode: 1'b0, kind: tpa_pkg::KIND_DATA};
      valid_q <= 1'b0;
    end else begin
      valid_q <= tick_q && (run || bypass);
      if (tick_q) begin
        char_q.word <= cur.word;
        char_q.sc <= cur.sc;
        char_q.encode <= (pf.mode_hi != tpa_pkg::LVL_LOW);
        if (wss_go || (wss_cnt_q != '0)) begin
          char_q.kind <= tpa_pkg::KIND_K285;
        end else if (phase_err_q) begin
          char_q.kind <= tpa_pkg::KIND_C07;
        end else begin
          char_q.kind <= tpa_pkg::KIND_DATA;
        end
      end
    end
  end

  // Register slave: address and data taken in either order
  assign wr_go = !awready_q && !wready_q && !bvalid_q;
  assign wr_sel = reg_sel(awaddr_q);
  assign rd_sel = reg_sel(s_axi_araddr);

  always_ff @(posedge sys_clk) begin : bus_write
    if (!rst_n) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= tpa_pkg::RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_sel == tpa_pkg::SEL_NONE) ? tpa_pkg::RESP_DECERR : tpa_pkg::RESP_OKAY;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin : csr
    if (!rst_n) begin
      ctrl_q <= tpa_pkg::CTRL_RST;
      irq_mask_q <= tpa_pkg::MASK_RST;
    end else if (wr_go && wstrb_q[0]) begin
      if (wr_sel == tpa_pkg::SEL_CTRL) begin
        ctrl_q <= wdata_q[tpa_pkg::CTRL_W-1:0];
      end else if (wr_sel == tpa_pkg::SEL_MASK) begin
        irq_mask_q <= wdata_q[tpa_pkg::IRQ_W-1:0];
      end
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[tpa_pkg::IRQ_PHASE_ERR] = err_set;
    irq_set[tpa_pkg::IRQ_RECENTRE] = recentre;
    irq_clr = '0;
    if (wr_go && wstrb_q[0] && (wr_sel == tpa_pkg::SEL_STAT)) begin
      irq_clr = wdata_q[tpa_pkg::IRQ_W-1:0];
    end
  end

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge sys_clk) begin : irq_path
    if (!rst_n) begin
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_sel == tpa_pkg::SEL_CTRL) begin
      rd_word[tpa_pkg::CTRL_W-1:0] = ctrl_q;
    end else if (rd_sel == tpa_pkg::SEL_STATUS) begin
      rd_word[tpa_pkg::ST_ERR] = phase_err_q;
      rd_word[tpa_pkg::ST_BYPASS] = bypass;
      rd_word[tpa_pkg::ST_RUN] = run;
      rd_word[tpa_pkg::ST_WSS] = (wss_cnt_q != '0);
    end else if (rd_sel == tpa_pkg::SEL_STAT) begin
      rd_word[tpa_pkg::IRQ_W-1:0] = irq_stat_q;
    end else if (rd_sel == tpa_pkg::SEL_MASK) begin
      rd_word[tpa_pkg::IRQ_W-1:0] = irq_mask_q;
    end
  end

  always_ff @(posedge sys_clk) begin : bus_read
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= tpa_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= (rd_sel == tpa_pkg::SEL_NONE) ? tpa_pkg::RESP_DECERR : tpa_pkg::RESP_OKAY;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign enc_char = char_q;
  assign enc_char_valid = valid_q;
  assign tx_error_flag = phase_err_q;
  assign irq = irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence wss_start_s;
    wss_go && phase_err_q;
  endsequence
  sequence wss_run_s;
    !phase_err_q && (char_q.kind == tpa_pkg::KIND_K285);
  endsequence

  err_hold_a: assert property ((phase_err_q && run && !bypass && !buf_centre)
    |=> phase_err_q)
    else $error("phase error dropped without reinit");
  c07_sub_a: assert property ((tick_q && phase_err_q && !wss_go && (wss_cnt_q == '0))
    |=> (char_q.kind == tpa_pkg::KIND_C07))
    else $error("host data sent during phase error");
  bypass_noerr_a: assert property (bypass |=> !phase_err_q)
    else $error("phase error in bypass mode");
  recentre_clr_a: assert property (wss_start_s |=> wss_run_s)
    else $error("word sync did not recentre");
  wss_len_a: assert property (wss_go |=> (wss_cnt_q == WSS_W'(tpa_pkg::WSS_LEN - 1)))
    else $error("word sync length wrong");
  init_enter_a: assert property ((run && !pf.init_n) |=> (st_q == tpa_pkg::ST_HOLD))
    else $error("init low not honoured");
  tick_space_a: assert property (tick_q |=> !tick_q [*7] ##1 tick_q)
    else $error("character clock spacing wrong");
  raw_word_a: assert property ((tick_q && bypass)
    |=> (char_q.word == $past({pf.ct, pf.d})) && enc_char_valid)
    else $error("bypass word not passed");
  enc_flag_a: assert property (tick_q |=> (char_q.encode == $past(pf.mode_hi != tpa_pkg::LVL_LOW)))
    else $error("encode flag mismatch");

endmodule : tpa_tx_front
`default_nettype wire

// file: tpa_host_model.sv
// Host transmit logic model: input clock, characters and buffer init
`timescale 1ns/1ps
`default_nettype none
module tpa_host_model (
  output logic tx_input_clock,
  output logic phase_buffer_init_n,
  output logic [7:0] tx_char_bits,
  output logic [1:0] tx_control_bits,
  output logic special_char_select,
  input wire logic [9:0] word_in,
  input wire logic sc_in,
  input wire logic fast,
  input wire logic hold_init
);
  initial begin
    tx_input_clock = 1'b0;
    #7;
    forever begin
      // Fast mode breaks the drift limit on purpose
      #(fast ? 75 : 100) tx_input_clock = ~tx_input_clock;
    end
  end
  // New character every cycle, stable around the rising edge
  always @(negedge tx_input_clock) begin
    {tx_control_bits, tx_char_bits} <= word_in;
    special_char_select <= sc_in;
  end
  // Init held low for whole input clock periods
  always @(posedge tx_input_clock) begin
    phase_buffer_init_n <= ~hold_init;
  end
endmodule : tpa_host_model
`default_nettype wire

// file: tpa_tx_front_tb.sv
// Self-checking testbench for the transmit front end
`timescale 1ns/1ps
`default_nettype none
module tpa_tx_front_tb;
  logic sys_clk, rst_n, cksel, dbl, fast, hold_init, sc_in;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic enc_valid, err, irq, tclk, init_n, sc_pin;
  logic [3:0] mode, wstrb;
  logic [9:0] word_in, w;
  logic [7:0] awaddr, araddr, d_pin;
  logic [1:0] bresp, rresp, ct_pin;
  logic [31:0] wdata, rdata, rd, seed;
  tpa_pkg::tpa_char_s ch;
  int miscompares, n_tests, i, k;

  tpa_host_model u_host (.tx_input_clock(tclk), .phase_buffer_init_n(init_n),
    .tx_char_bits(d_pin), .tx_control_bits(ct_pin), .special_char_select(sc_pin),
    .word_in(word_in), .sc_in(sc_in), .fast(fast), .hold_init(hold_init));

  tpa_tx_front u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .tx_input_clock(tclk),
    .phase_buffer_init_n(init_n), .tx_char_bits(d_pin), .tx_control_bits(ct_pin),
    .special_char_select(sc_pin), .tx_mode_select(mode), .tx_input_clock_source_sel(cksel),
    .tx_double_edge_capture(dbl), .enc_char(ch), .enc_char_valid(enc_valid),
    .tx_error_flag(err), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic exp_sc(input logic [3:0] m, input logic s);
    return (m[1:0] != 2'b10) ? s : 1'b0;
  endfunction : exp_sc

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 50) begin
      miscompares++;
      final_report();
    end
    chk(bresp, er);
    @(posedge sys_clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    rready <= 1'b0;
    if (n == 50) begin
      miscompares++;
      final_report();
    end
    chk(rresp, er);
    @(posedge sys_clk);
  endtask : axi_rd

  task automatic next_char();
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (enc_valid === 1'b1) break;
    end
    if (n == 40) begin
      miscompares++;
      final_report();
    end
  endtask : next_char

  task automatic wait_err();
    for (i = 0; i < 4000 && err !== 1'b1; i++) @(posedge sys_clk);
    if (i == 4000) begin
      miscompares++;
      final_report();
    end
  endtask : wait_err

  initial begin
    rst_n = 1'b0;
    {cksel, dbl, fast, hold_init, sc_in} = 5'b10010;
    mode = 4'b1000;
    word_in = 10'h000;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    seed = 32'h0000_0e52;
    miscompares = 0;
    n_tests = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    axi_rd(tpa_pkg::ADDR_CTRL, rd, tpa_pkg::RESP_OKAY);
    chk(rd, 32'h0000_0000);
    axi_rd(tpa_pkg::ADDR_IRQ_MASK, rd, tpa_pkg::RESP_OKAY);
    chk(rd, 32'h0000_0000);
    axi_rd(8'h10, rd, tpa_pkg::RESP_DECERR);
    chk(rd, 32'h0000_0000);
    axi_wr(8'h10, 32'hffff_ffff, tpa_pkg::RESP_DECERR);
    axi_wr(tpa_pkg::ADDR_IRQ_MASK, 32'h0000_0003, tpa_pkg::RESP_OKAY);
    // Soft init keeps the buffer held after the pin is released
    axi_wr(tpa_pkg::ADDR_CTRL, 32'h0000_0001, tpa_pkg::RESP_OKAY);
    hold_init <= 1'b0;
    repeat (40) @(posedge sys_clk);
    axi_rd(tpa_pkg::ADDR_CTRL, rd, tpa_pkg::RESP_OKAY);
    chk(rd, 32'h0000_0001);
    axi_rd(tpa_pkg::ADDR_STATUS, rd, tpa_pkg::RESP_OKAY);
    chk(rd, 32'h0000_0000);
    axi_wr(tpa_pkg::ADDR_CTRL, 32'h0000_0000, tpa_pkg::RESP_OKAY);
    // Random characters and modes through the buffer
    for (k = 0; k < 8; k++) begin
      rd = xs();
      w = rd[9:0];
      word_in <= w;
      sc_in <= rd[12];
      mode <= {k[0] ? 2'b10 : 2'b00, (rd[11:10] == 2'b11) ? 2'b01 : rd[11:10]};
      repeat (120) @(posedge sys_clk);
      for (i = 0; i < 3; i++) begin
        next_char();
        chk(ch.word, w);
        chk(ch.encode, mode[3:2] != 2'b00);
        chk(ch.sc, exp_sc(mode, sc_in));
        chk(ch.kind, tpa_pkg::KIND_DATA);
      end
    end
    chk(err, 1'b0);
    // Drift too far: error, substitution, interrupt
    fast <= 1'b1;
    wait_err();
    chk(err, 1'b1);
    fast <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk(irq, 1'b1);
    next_char();
    chk(ch.kind, tpa_pkg::KIND_C07);
    repeat (300) @(posedge sys_clk);
    chk(err, 1'b1);
    axi_wr(tpa_pkg::ADDR_IRQ_STAT, 32'h0000_0001, tpa_pkg::RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'b0);
    // Word sync recentres and clears the error
    mode <= 4'b0100;
    word_in <= tpa_pkg::WSS_CMD;
    k = 0;
    for (i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      if (enc_valid === 1'b1 && ch.kind === tpa_pkg::KIND_K285) k++;
      if (i == 200) word_in <= 10'h055;
    end
    chk(k, 2 * tpa_pkg::WSS_LEN);
    chk(err, 1'b0);
    axi_rd(tpa_pkg::ADDR_IRQ_STAT, rd, tpa_pkg::RESP_OKAY);
    chk(rd[1], 1'b1);
    // Error cleared by reinitialising the buffer
    mode <= 4'b1000;
    fast <= 1'b1;
    wait_err();
    chk(err, 1'b1);
    fast <= 1'b0;
    hold_init <= 1'b1;
    repeat (60) @(posedge sys_clk);
    chk(err, 1'b0);
    hold_init <= 1'b0;
    // Bypass: pins straight through, no phase error
    cksel <= 1'b0;
    dbl <= 1'b0;
    fast <= 1'b1;
    mode <= 4'b0000;
    rd = xs();
    w = rd[9:0];
    word_in <= w;
    repeat (100) @(posedge sys_clk);
    axi_rd(tpa_pkg::ADDR_STATUS, rd, tpa_pkg::RESP_OKAY);
    chk(rd[1], 1'b1);
    for (i = 0; i < 3; i++) begin
      next_char();
      chk(ch.word, w);
    end
    k = 0;
    for (i = 0; i < 800; i++) begin
      @(posedge sys_clk);
      if (err !== 1'b0) k++;
    end
    chk(k, 0);
    // Double-edge capture brings the buffer back in
    dbl <= 1'b1;
    repeat (20) @(posedge sys_clk);
    axi_rd(tpa_pkg::ADDR_STATUS, rd, tpa_pkg::RESP_OKAY);
    chk(rd[1], 1'b0);
    final_report();
  end
endmodule : tpa_tx_front_tb
`default_nettype wire
